// ---- stmi_params.svh ----
// Offsets, segment thresholds, reset values and timing figures of the indicator
`ifndef STMI_PARAMS_SVH
`define STMI_PARAMS_SVH

// Clock rate and the 1 ms time base
`define STMI_CLK_HZ 40000000
`define STMI_TICK_CYC (`STMI_CLK_HZ / 1000)

// Times in milliseconds
`define STMI_RATE_HOLD_MS 3000
`define STMI_TACT_HOLD_MS 5000
`define STMI_XFER_HOLD_MS 8000
`define STMI_GAP_MS 200
`define STMI_FLASH_MS 250
`define STMI_PWRON_STEP_MS 200

// Count saturation and segment thresholds
`define STMI_CNT_MAX 14'h270f
`define STMI_CNT_TH5 14'h0064
`define STMI_CNT_TH4 14'h0032
`define STMI_CNT_TH3 14'h000a
`define STMI_CNT_TH2 14'h0005
`define STMI_CNT_TH1 14'h0001
`define STMI_PCT_TH5 7'h51
`define STMI_PCT_TH4 7'h3d
`define STMI_PCT_TH3 7'h29
`define STMI_PCT_TH2 7'h15
`define STMI_PCT_TH1 7'h01

// Register offsets and reset values
`define STMI_REG_CTRL 4'h0
`define STMI_REG_MATCH 4'h4
`define STMI_REG_STATUS 4'h8
`define STMI_REG_COUNT 4'hc
`define STMI_CTRL_RST 8'h00
`define STMI_MATCH_RST 14'h0001
`define STMI_PWRON_LAST 3'h5

`endif

// ---- stmi_pkg.sv ----
// Types shared by the indicator block and its environment
package stmi_pkg;
	typedef enum logic [1:0] {MODE_NORMAL, MODE_RATE, MODE_TACT} stmi_mode_t;
	typedef enum logic [1:0] {SYS_PWRON, SYS_RUN, SYS_LOCK, SYS_XFER} stmi_sys_t;
	typedef enum logic [2:0] {CMD_FIRST_TRIAL_START, CMD_SECOND_TRIAL_START,
		CMD_ONLINE_TRIAL_ENABLE, CMD_QUIT, CMD_LOCK, CMD_UNLOCK} stmi_cmd_t;
	typedef enum logic [1:0] {REC_RATE, REC_TACT, REC_ONLINE} stmi_rec_kind_t;

	typedef struct packed {
		logic valid;
		stmi_cmd_t code;
	} stmi_cmd_req_t;

	typedef struct packed {
		logic valid;
		logic ok;
	} stmi_resp_t;

	typedef struct packed {
		logic valid;
		stmi_rec_kind_t kind;
		logic add_good;
		logic add_scan;
		logic [13:0] good;
		logic [13:0] scan;
		logic [6:0] rate;
	} stmi_rec_t;

	typedef struct packed {
		logic add_scan;
		logic add_count;
		logic send_after_trig;
		logic [1:0] multi;
		logic trig_test_tact;
		logic trig_test_en;
		logic show_en;
	} stmi_ctrl_t;
endpackage

// ---- stmi_top.sv ----
// Test-mode and read-quality indicator for a scanning code reader
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "stmi_params.svh"

// Behaviour
// - Holding button five seconds, two segments lit, release selects tact check.
// - Button or command started test mode keeps laser on regardless of trigger.
// - Tact check: dark while decoding; result after 0.2 s without decode.
// - Count to segments: 100+ five, 50 four, 10 three, 5 two, 1 one.
// - Tact lamp green when count nonzero and at least match count, else red.
// - Test modes drive lamp but never the external pass/fail outputs.
// - Reported decode count saturates at 9999.
// - Same label within 0.2 s continues count; different label starts new one.
// - Another button press during a button or command started test mode returns to normal.
// - Host trial-start commands enter the matching test mode.
// - Trigger-start option: trigger selects test mode, trial commands refused.
// - Online enable command answers OK, sets flag lost at reset.
// - Online mode reads normally, shows and sends after trigger goes off.
// - Online record: good count, scan count incl. empty scans.
// - Quit command clears online mode and answers OK.
// - Rate mode: segments per 20 percent step, lamp green unless zero.
// - Normal mode shows count only if online, or if enabled and a qualifying mode set.
// - Rate results carry no decode or scan counts.
// - Power-on walk up, setup all flash, transfer wait 1,3,5 flash.
// - Holding button eight seconds enters settings-transfer wait.
// - Lock forces laser off, bottom flashes; unlock restarts power-on.
// - Fault flashes segment 2,3 or 4; link error flashes top until press.
module stmi_top import stmi_pkg::*; #(
	parameter int TICK_CYC = `STMI_TICK_CYC,
	parameter int RATE_HOLD_MS = `STMI_RATE_HOLD_MS,
	parameter int TACT_HOLD_MS = `STMI_TACT_HOLD_MS,
	parameter int XFER_HOLD_MS = `STMI_XFER_HOLD_MS,
	parameter int GAP_MS = `STMI_GAP_MS,
	parameter int FLASH_MS = `STMI_FLASH_MS,
	parameter int STEP_MS = `STMI_PWRON_STEP_MS
) (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic [3:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire logic BUTTON,
	input wire logic TRIGGER,
	input wire logic DECODE,
	input wire logic [15:0] LABEL_TAG,
	input wire logic SCAN,
	input wire logic RATE_VALID,
	input wire logic [6:0] RATE_PCT,
	input wire logic RESULT_PASS,
	input wire logic RESULT_FAIL,
	input wire logic SETUP_BUSY,
	input wire logic XFER_DONE,
	input wire logic [1:0] FAULT_SEL,
	input wire logic LINK_ERR,
	input wire stmi_cmd_req_t CMD,
	output var stmi_resp_t RESP,
	output var stmi_rec_t REC,
	output logic [4:0] SEGMENT,
	output logic LAMP_GREEN,
	output logic LAMP_RED,
	output logic PASS_FAIL_GOOD,
	output logic PASS_FAIL_BAD,
	output logic LASER_ON
);
	stmi_mode_t mode_r, mode_q_r;
	stmi_sys_t sys_r;
	stmi_ctrl_t ctrl_r;
	logic [13:0] match_r, good_r, scan_r, fin_good_r, fin_scan_r;
	logic [15:0] tick_cnt_r, label_r;
	logic [12:0] hold_r;
	logic [7:0] gap_r, flash_cnt_r, step_ms_r;
	logic [2:0] step_r;
	logic [4:0] res_seg_r;
	logic tick_r, flash_r, btn_q_r, trig_q_r, arm_r, online_r, plc_r;
	logic counting_r, fin_r, show_cond;
	logic btn_press, btn_release, cmd_trial, cmd_is;

	// Thermometer code of n lit segments from the bottom
	function automatic logic [4:0] therm(input logic [2:0] n);
		logic [4:0] t;
		t = 5'h00;
		for (int i = 0; i < 5; i++) begin
			t[i] = (3'(i) < n);
		end
		return t;
	endfunction

	// Decode count to segment number
	function automatic logic [2:0] cnt_lvl(input logic [13:0] c);
		if (c >= `STMI_CNT_TH5) return 3'h5;
		else if (c >= `STMI_CNT_TH4) return 3'h4;
		else if (c >= `STMI_CNT_TH3) return 3'h3;
		else if (c >= `STMI_CNT_TH2) return 3'h2;
		else if (c >= `STMI_CNT_TH1) return 3'h1;
		else return 3'h0;
	endfunction

	// Read rate percentage to segment number
	function automatic logic [2:0] pct_lvl(input logic [6:0] p);
		if (p >= `STMI_PCT_TH5) return 3'h5;
		else if (p >= `STMI_PCT_TH4) return 3'h4;
		else if (p >= `STMI_PCT_TH3) return 3'h3;
		else if (p >= `STMI_PCT_TH2) return 3'h2;
		else if (p >= `STMI_PCT_TH1) return 3'h1;
		else return 3'h0;
	endfunction

	// Saturating count step
	function automatic logic [13:0] sat_inc(input logic [13:0] c);
		return (c == `STMI_CNT_MAX) ? c : c + 14'h0001;
	endfunction

	assign btn_press = BUTTON & ~btn_q_r;
	assign btn_release = ~BUTTON & btn_q_r;
	assign cmd_is = CMD.valid;
	assign cmd_trial = cmd_is && (CMD.code == CMD_FIRST_TRIAL_START ||
		CMD.code == CMD_SECOND_TRIAL_START);
	assign show_cond = ctrl_r.show_en && (ctrl_r.multi == 2'h1 ||
		ctrl_r.multi == 2'h2 || ctrl_r.send_after_trig ||
		ctrl_r.add_count);

	// 1 ms time base and flash phase
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			tick_cnt_r <= 16'h0000;
			tick_r <= 1'b0;
			flash_cnt_r <= 8'h00;
			flash_r <= 1'b0;
		end else begin
			tick_r <= (tick_cnt_r == 16'(TICK_CYC - 1));
			tick_cnt_r <= (tick_cnt_r == 16'(TICK_CYC - 1)) ? 16'h0000 :
				tick_cnt_r + 16'h0001;
			if (tick_r) begin
				if (flash_cnt_r == 8'(FLASH_MS - 1)) begin
					flash_cnt_r <= 8'h00;
					flash_r <= ~flash_r;
				end else begin
					flash_cnt_r <= flash_cnt_r + 8'h01;
				end
			end
		end
	end

	// Button and trigger edges, hold time, selection arming
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			btn_q_r <= 1'b0;
			trig_q_r <= 1'b0;
			hold_r <= 13'h0000;
			arm_r <= 1'b0;
		end else begin
			btn_q_r <= BUTTON;
			trig_q_r <= TRIGGER;
			if (!BUTTON) begin
				hold_r <= 13'h0000;
			end else if (tick_r && hold_r < 13'(XFER_HOLD_MS)) begin
				hold_r <= hold_r + 13'h0001;
			end
			if (btn_press) begin
				arm_r <= (mode_r == MODE_NORMAL) && (sys_r == SYS_RUN);
			end else if (btn_release || sys_r != SYS_RUN) begin
				arm_r <= 1'b0;
			end
		end
	end

	// Unit state: power-on walk, lock, transfer wait
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			sys_r <= SYS_PWRON;
			step_r <= 3'h0;
			step_ms_r <= 8'h00;
		end else if (cmd_is && CMD.code == CMD_LOCK) begin
			sys_r <= SYS_LOCK;
		end else begin
			case (sys_r)
				SYS_PWRON: begin
					if (tick_r) begin
						if (step_ms_r == 8'(STEP_MS - 1)) begin
							step_ms_r <= 8'h00;
							if (step_r == `STMI_PWRON_LAST) begin
								sys_r <= SYS_RUN;
							end else begin
								step_r <= step_r + 3'h1;
							end
						end else begin
							step_ms_r <= step_ms_r + 8'h01;
						end
					end
				end
				SYS_RUN: begin
					if (BUTTON && arm_r && hold_r >= 13'(XFER_HOLD_MS)) begin
						sys_r <= SYS_XFER;
					end
				end
				SYS_LOCK: begin
					if (cmd_is && CMD.code == CMD_UNLOCK) begin
						sys_r <= SYS_PWRON;
						step_r <= 3'h0;
						step_ms_r <= 8'h00;
					end
				end
				SYS_XFER: begin
					if (XFER_DONE) begin
						sys_r <= SYS_RUN;
					end
				end
				default: sys_r <= SYS_PWRON;
			endcase
		end
	end

	// Test mode selection
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			mode_r <= MODE_NORMAL;
		end else if (sys_r != SYS_RUN) begin
			mode_r <= MODE_NORMAL;
		end else if (ctrl_r.trig_test_en) begin
			if (TRIGGER) begin
				mode_r <= ctrl_r.trig_test_tact ? MODE_TACT : MODE_RATE;
			end else begin
				mode_r <= MODE_NORMAL;
			end
		end else if (btn_press && mode_r != MODE_NORMAL) begin
			mode_r <= MODE_NORMAL;
		end else if (btn_release && arm_r &&
			hold_r >= 13'(TACT_HOLD_MS)) begin
			mode_r <= MODE_TACT;
		end else if (btn_release && arm_r &&
			hold_r >= 13'(RATE_HOLD_MS)) begin
			mode_r <= MODE_RATE;
		end else if (cmd_trial) begin
			mode_r <= (CMD.code == CMD_FIRST_TRIAL_START) ? MODE_RATE :
				MODE_TACT;
		end
	end

	// Command answers and the volatile online flag
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			RESP <= '0;
			online_r <= 1'b0;
		end else begin
			RESP.valid <= cmd_is;
			RESP.ok <= !(cmd_trial && ctrl_r.trig_test_en);
			if (cmd_is && CMD.code == CMD_ONLINE_TRIAL_ENABLE) begin
				online_r <= 1'b1;
			end else if (cmd_is && CMD.code == CMD_QUIT) begin
				online_r <= 1'b0;
			end
		end
	end

	// Decode and scan counting per label or per trigger
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			good_r <= 14'h0000;
			scan_r <= 14'h0000;
			label_r <= 16'h0000;
			gap_r <= 8'h00;
			counting_r <= 1'b0;
			fin_r <= 1'b0;
			fin_good_r <= 14'h0000;
			fin_scan_r <= 14'h0000;
		end else begin
			fin_r <= 1'b0;
			if (mode_r != mode_q_r || sys_r != SYS_RUN ||
				mode_r == MODE_RATE) begin
				counting_r <= 1'b0;
			end else if (mode_r == MODE_TACT) begin
				if (DECODE) begin
					gap_r <= 8'h00;
					if (counting_r && LABEL_TAG == label_r) begin
						good_r <= sat_inc(good_r);
					end else begin
						fin_r <= counting_r;
						fin_good_r <= good_r;
						fin_scan_r <= scan_r;
						good_r <= 14'h0001;
						scan_r <= 14'h0000;
						label_r <= LABEL_TAG;
						counting_r <= 1'b1;
					end
				end else if (counting_r && tick_r) begin
					if (gap_r == 8'(GAP_MS - 1)) begin
						fin_r <= 1'b1;
						fin_good_r <= good_r;
						fin_scan_r <= scan_r;
						counting_r <= 1'b0;
					end else begin
						gap_r <= gap_r + 8'h01;
					end
				end
			end else if (!ctrl_r.trig_test_en) begin
				if (TRIGGER && !trig_q_r) begin
					good_r <= 14'h0000;
					scan_r <= 14'h0000;
					counting_r <= 1'b1;
				end else if (!TRIGGER && trig_q_r && counting_r) begin
					fin_r <= 1'b1;
					fin_good_r <= good_r;
					fin_scan_r <= scan_r;
					counting_r <= 1'b0;
				end else if (counting_r) begin
					if (DECODE) begin
						good_r <= sat_inc(good_r);
					end
					if (SCAN) begin
						scan_r <= sat_inc(scan_r);
					end
				end
			end
		end
	end

	// Result display, lamp and records
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			mode_q_r <= MODE_NORMAL;
			res_seg_r <= 5'h00;
			LAMP_GREEN <= 1'b0;
			LAMP_RED <= 1'b0;
			REC <= '0;
		end else begin
			mode_q_r <= mode_r;
			REC.valid <= 1'b0;
			if (mode_r != mode_q_r) begin
				res_seg_r <= 5'h00;
				LAMP_GREEN <= 1'b0;
				LAMP_RED <= 1'b0;
			end else begin
				case (mode_r)
					MODE_RATE: begin
						if (RATE_VALID) begin
							res_seg_r <= therm(pct_lvl(RATE_PCT));
							LAMP_GREEN <= (RATE_PCT != 7'h00);
							LAMP_RED <= (RATE_PCT == 7'h00);
							REC.valid <= 1'b1;
							REC.kind <= REC_RATE;
							REC.add_good <= 1'b0;
							REC.add_scan <= 1'b0;
							REC.rate <= RATE_PCT;
						end
					end
					MODE_TACT: begin
						if (counting_r) begin
							res_seg_r <= 5'h00;
						end else if (fin_r) begin
							res_seg_r <= therm(cnt_lvl(fin_good_r));
						end
						if (fin_r) begin
							LAMP_GREEN <= fin_good_r != 14'h0000 &&
								fin_good_r >= match_r;
							LAMP_RED <= fin_good_r == 14'h0000 ||
								fin_good_r < match_r;
							REC.valid <= 1'b1;
							REC.kind <= REC_TACT;
							REC.add_good <= 1'b1;
							REC.add_scan <= ctrl_r.add_scan;
							REC.good <= fin_good_r;
							REC.scan <= fin_scan_r;
						end
					end
					default: begin
						if (RESULT_PASS || RESULT_FAIL) begin
							LAMP_GREEN <= RESULT_PASS;
							LAMP_RED <= RESULT_FAIL;
						end
						if (fin_r && (online_r || show_cond)) begin
							res_seg_r <= therm(cnt_lvl(fin_good_r));
						end
						if (fin_r && online_r) begin
							REC.valid <= 1'b1;
							REC.kind <= REC_ONLINE;
							REC.add_good <= 1'b1;
							REC.add_scan <= 1'b1;
							REC.good <= fin_good_r;
							REC.scan <= fin_scan_r;
						end
					end
				endcase
			end
		end
	end

	// Link error stays until a button press; a new error wins
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			plc_r <= 1'b0;
		end else begin
			plc_r <= LINK_ERR | (plc_r & ~btn_press);
		end
	end

	// Segment drive with status patterns on top
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			SEGMENT <= 5'h00;
		end else begin
			case (sys_r)
				SYS_PWRON: SEGMENT <= therm(step_r);
				SYS_LOCK: SEGMENT <= {4'h0, flash_r};
				SYS_XFER: SEGMENT <= flash_r ? 5'h15 : 5'h00;
				default: begin
					if (SETUP_BUSY) begin
						SEGMENT <= flash_r ? 5'h1f : 5'h00;
					end else if (FAULT_SEL != 2'h0) begin
						SEGMENT <= flash_r ? 5'h10 >> FAULT_SEL : 5'h00;
					end else if (plc_r) begin
						SEGMENT <= {flash_r, 4'h0};
					end else if (arm_r && hold_r >= 13'(TACT_HOLD_MS)) begin
						SEGMENT <= therm(3'h2);
					end else if (arm_r && hold_r >= 13'(RATE_HOLD_MS)) begin
						SEGMENT <= therm(3'h1);
					end else begin
						SEGMENT <= res_seg_r;
					end
				end
			endcase
		end
	end

	// Laser and external pass/fail outputs
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			LASER_ON <= 1'b0;
			PASS_FAIL_GOOD <= 1'b0;
			PASS_FAIL_BAD <= 1'b0;
		end else begin
			if (sys_r != SYS_RUN) begin
				LASER_ON <= 1'b0;
			end else if (mode_r != MODE_NORMAL) begin
				LASER_ON <= 1'b1;
			end else begin
				LASER_ON <= TRIGGER && !ctrl_r.trig_test_en;
			end
			PASS_FAIL_GOOD <= (mode_r == MODE_NORMAL) && RESULT_PASS;
			PASS_FAIL_BAD <= (mode_r == MODE_NORMAL) && RESULT_FAIL;
		end
	end

	// Register writes
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			ctrl_r <= `STMI_CTRL_RST;
			match_r <= `STMI_MATCH_RST;
		end else if (WR) begin
			if (ADDR == `STMI_REG_CTRL) begin
				ctrl_r <= WDATA[7:0];
			end
			if (ADDR == `STMI_REG_MATCH) begin
				match_r <= WDATA[13:0];
			end
		end
	end

	// Register reads, data in the cycle after the strobe only
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			RDATA <= 32'h0000_0000;
		end else if (RD) begin
			case (ADDR)
				`STMI_REG_CTRL: RDATA <= {24'h00_0000, ctrl_r};
				`STMI_REG_MATCH: RDATA <= {18'h0_0000, match_r};
				`STMI_REG_STATUS: RDATA <= {25'h000_0000, online_r,
					counting_r, plc_r, sys_r, mode_r};
				`STMI_REG_COUNT: RDATA <= {4'h0, fin_scan_r, fin_good_r};
				default: RDATA <= 32'h0000_0000;
			endcase
		end else begin
			RDATA <= 32'h0000_0000;
		end
	end
endmodule // stmi_top
`default_nettype wire

// ---- stmi_top_monitor.sv ----
// Port-level checks on the indicator block
`timescale 1ns/1ps
`default_nettype none
module stmi_top_monitor import stmi_pkg::*; (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic RESULT_PASS,
	input wire stmi_cmd_req_t CMD,
	input wire stmi_resp_t RESP,
	input wire stmi_rec_t REC,
	input wire logic [4:0] SEGMENT,
	input wire logic LAMP_GREEN,
	input wire logic LAMP_RED,
	input wire logic PASS_FAIL_GOOD,
	input wire logic LASER_ON
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);

	// Command answers and refusals
	property p_resp; CMD.valid |=> RESP.valid; endproperty
	a_resp: assert property (p_resp)
		else $error("command without answer");
	property p_noresp; RESP.valid |-> $past(CMD.valid); endproperty
	a_noresp: assert property (p_noresp)
		else $error("answer without command");
	property p_refuse;
		RESP.valid && !RESP.ok |-> $past(CMD.code) inside
			{CMD_FIRST_TRIAL_START, CMD_SECOND_TRIAL_START};
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("non trial command refused");
	// External good output only follows a pass result
	property p_pf; PASS_FAIL_GOOD |-> $past(RESULT_PASS); endproperty
	a_pf: assert property (p_pf)
		else $error("pass output without result");
	// Record contents
	property p_sat;
		REC.valid |-> REC.good <= 14'h270f && REC.scan <= 14'h270f;
	endproperty
	a_sat: assert property (p_sat)
		else $error("count above saturation");
	property p_ratecnt;
		REC.valid && REC.kind == REC_RATE |-> !REC.add_good && !REC.add_scan;
	endproperty
	a_ratecnt: assert property (p_ratecnt)
		else $error("rate record carries counts");
	property p_ratelamp;
		REC.valid && REC.kind == REC_RATE |->
			LAMP_GREEN == (REC.rate != 7'h00) && LAMP_RED == (REC.rate == 7'h00);
	endproperty
	a_ratelamp: assert property (p_ratelamp)
		else $error("rate lamp wrong");
	property p_rate5;
		REC.valid && REC.kind == REC_RATE && REC.rate >= 7'h51 |=>
			SEGMENT == 5'h1f;
	endproperty
	a_rate5: assert property (p_rate5)
		else $error("top rate band not five segments");
	property p_tact5;
		REC.valid && REC.kind == REC_TACT && REC.good >= 14'h0064 |->
			##[0:3] SEGMENT == 5'h1f;
	endproperty
	a_tact5: assert property (p_tact5)
		else $error("high count not five segments");
	property p_laser; REC.valid && REC.kind == REC_TACT |-> LASER_ON; endproperty
	a_laser: assert property (p_laser)
		else $error("laser off in tact check");
	property p_lamp; !(LAMP_GREEN && LAMP_RED); endproperty
	a_lamp: assert property (p_lamp)
		else $error("both lamp colours lit");

	// Main scenarios reached
	c_rate: cover property (REC.valid && REC.kind == REC_RATE);
	c_tact: cover property (REC.valid && REC.kind == REC_TACT);
	c_online: cover property (REC.valid && REC.kind == REC_ONLINE);
endmodule // stmi_top_monitor

bind stmi_top stmi_top_monitor stmi_top_monitor_inst (.CLOCK(CLOCK),
	.RST(RST), .RESULT_PASS(RESULT_PASS), .CMD(CMD), .RESP(RESP), .REC(REC),
	.SEGMENT(SEGMENT), .LAMP_GREEN(LAMP_GREEN), .LAMP_RED(LAMP_RED),
	.PASS_FAIL_GOOD(PASS_FAIL_GOOD), .LASER_ON(LASER_ON));
`default_nettype wire

// ---- stmi_host_model.sv ----
// Host terminal model issuing decoded commands
`timescale 1ns/1ps
`default_nettype none
module stmi_host_model import stmi_pkg::*; (
	input wire logic clk,
	output var stmi_cmd_req_t cmd,
	input wire stmi_resp_t resp
);
	logic got_valid;
	logic got_ok;
	initial begin
		cmd = '0;
	end
	// Uppercase commands arrive decoded; one pulse, answer next cycle
	task automatic send(input stmi_cmd_t c);
		@(posedge clk);
		cmd <= '{valid: 1'b1, code: c};
		@(posedge clk);
		cmd <= '0;
		#1;
		got_valid = resp.valid;
		got_ok = resp.ok;
	endtask
endmodule // stmi_host_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the indicator block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
	$display("[ERR] %0t %h %h", $time, a, b); end end
module testbench import stmi_pkg::*;;
	logic CLOCK = 0, RST = 1, WR = 0, RD = 0, BUTTON = 0, TRIGGER = 0;
	logic DECODE = 0, SCAN = 0, RATE_VALID = 0, RESULT_PASS = 0;
	logic RESULT_FAIL = 0, SETUP_BUSY = 0, XFER_DONE = 0, LINK_ERR = 0;
	logic [1:0] FAULT_SEL = 0;
	logic [3:0] ADDR = 0;
	logic [31:0] WDATA = 0;
	logic [15:0] LABEL_TAG = 0;
	logic [6:0] RATE_PCT = 0;
	logic [31:0] RDATA, rd_val;
	stmi_cmd_req_t CMD;
	stmi_resp_t RESP;
	stmi_rec_t REC;
	logic [4:0] SEGMENT;
	logic LAMP_GREEN, LAMP_RED, PASS_FAIL_GOOD, PASS_FAIL_BAD, LASER_ON;
	int n_errors = 0;
	int cmp_count = 0;

	stmi_top #(.TICK_CYC(4), .RATE_HOLD_MS(3), .TACT_HOLD_MS(5),
		.XFER_HOLD_MS(8), .GAP_MS(4), .FLASH_MS(2), .STEP_MS(2))
	stmi_top_inst (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
		.WR(WR), .RD(RD), .RDATA(RDATA), .BUTTON(BUTTON), .TRIGGER(TRIGGER),
		.DECODE(DECODE), .LABEL_TAG(LABEL_TAG), .SCAN(SCAN),
		.RATE_VALID(RATE_VALID), .RATE_PCT(RATE_PCT), .RESULT_PASS(RESULT_PASS),
		.RESULT_FAIL(RESULT_FAIL), .SETUP_BUSY(SETUP_BUSY),
		.XFER_DONE(XFER_DONE), .FAULT_SEL(FAULT_SEL), .LINK_ERR(LINK_ERR),
		.CMD(CMD), .RESP(RESP), .REC(REC), .SEGMENT(SEGMENT),
		.LAMP_GREEN(LAMP_GREEN), .LAMP_RED(LAMP_RED),
		.PASS_FAIL_GOOD(PASS_FAIL_GOOD), .PASS_FAIL_BAD(PASS_FAIL_BAD),
		.LASER_ON(LASER_ON));
	stmi_host_model stmi_host_model_inst (.clk(CLOCK), .cmd(CMD), .resp(RESP));

	// 40 MHz clock
	initial begin
		forever #12.5 CLOCK = ~CLOCK;
	end

	// Expected segment count and pattern
	function automatic int segs(input int c);
		segs = (c >= 100) + (c >= 50) + (c >= 10) + (c >= 5) + (c >= 1);
	endfunction
	function automatic logic [4:0] therm(input int n);
		therm = 5'((1 << n) - 1);
	endfunction

	// Bus, stimulus and wait helpers
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLOCK);
		WR <= 1'b0;
	endtask
	task rd(input logic [3:0] a);
		@(posedge CLOCK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLOCK);
		RD <= 1'b0;
		#1 rd_val = RDATA;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge CLOCK);
	endtask
	task dec(input logic [15:0] t);
		@(posedge CLOCK);
		DECODE <= 1'b1;
		LABEL_TAG <= t;
		@(posedge CLOCK);
		DECODE <= 1'b0;
	endtask
	task press;
		@(posedge CLOCK);
		BUTTON <= 1'b1;
		@(posedge CLOCK);
		BUTTON <= 1'b0;
	endtask
	task wait_rec;
		int i;
		i = 0;
		do begin
			@(posedge CLOCK);
			#1 i++;
		end while (REC.valid !== 1'b1 && i < 600);
		if (REC.valid !== 1'b1) begin
			n_errors++;
			print_verdict();
		end
	endtask
	task cmd_chk(input stmi_cmd_t c, input logic ok);
		stmi_host_model_inst.send(c);
		`CHK(stmi_host_model_inst.got_valid, 1'b1)
		`CHK(stmi_host_model_inst.got_ok, ok)
	endtask
	// Flash watch: pattern seen, nothing but pattern or dark
	task watch(input logic [4:0] pat, output logic [1:0] res);
		logic hit, bad;
		hit = 0;
		bad = 0;
		cyc(2);
		repeat (20) begin
			@(posedge CLOCK);
			#1 hit |= (SEGMENT === pat);
			bad |= (SEGMENT !== pat && SEGMENT !== 5'h00);
		end
		res = {hit, bad};
	endtask

	// Power-on walk reaches all segments, then run state and match register default
	task t_walk;
		logic seen;
		seen = 0;
		repeat (60) begin
			@(posedge CLOCK);
			#1 if (SEGMENT === 5'h1f) seen = 1;
		end
		`CHK(seen, 1'b1)
		cyc(10);
		rd(4'h8);
		`CHK(rd_val[3:2], 2'h1)
		rd(4'h4);
		`CHK(rd_val, 32'h0000_0001)
		rd(4'h2);
		`CHK(rd_val, 32'h0000_0000)
	endtask

	// Tact check: counts, bands, lamp, saturation, label change
	task t_tact;
		int cnt[4] = '{4, 5, 100, 10000};
		int e;
		wr(4'h4, 32'h0000_0005);
		cmd_chk(CMD_SECOND_TRIAL_START, 1'b1);
		rd(4'h8);
		`CHK(rd_val[1:0], 2'h2)
		foreach (cnt[k]) begin
			repeat (cnt[k]) begin
				dec(16'h00a5);
				cyc(2);
			end
			#1 `CHK(SEGMENT, 5'h00)
			wait_rec;
			e = (cnt[k] > 9999) ? 9999 : cnt[k];
			`CHK(REC.good, 14'(e))
			cyc(3);
			#1 `CHK(SEGMENT, therm(segs(e)))
			`CHK(LAMP_GREEN, e >= 5)
			`CHK(LASER_ON, 1'b1)
		end
		@(posedge CLOCK);
		RESULT_PASS <= 1'b1;
		@(posedge CLOCK);
		RESULT_PASS <= 1'b0;
		#1 `CHK(PASS_FAIL_GOOD, 1'b0)
		dec(16'h0001);
		cyc(2);
		dec(16'h0001);
		cyc(2);
		dec(16'h0002);
		wait_rec;
		`CHK(REC.good, 14'h0002)
		wait_rec;
		`CHK(REC.good, 14'h0001)
		press();
		rd(4'h8);
		`CHK(rd_val[1:0], 2'h0)
	endtask

	// Rate check across every band edge
	task t_rate;
		int pct[11] = '{100, 81, 80, 61, 60, 41, 40, 21, 20, 1, 0};
		cmd_chk(CMD_FIRST_TRIAL_START, 1'b1);
		foreach (pct[k]) begin
			@(posedge CLOCK);
			RATE_VALID <= 1'b1;
			RATE_PCT <= 7'(pct[k]);
			@(posedge CLOCK);
			RATE_VALID <= 1'b0;
			#1 `CHK(REC.valid, 1'b1)
			`CHK(LAMP_GREEN, pct[k] != 0)
			`CHK(REC.add_good, 1'b0)
			@(posedge CLOCK);
			#1 `CHK(SEGMENT, therm((pct[k] + 19) / 20))
		end
		press();
	endtask

	// Trigger-start option refuses host trial commands
	task t_trig;
		wr(4'h0, 32'h0000_0002);
		cmd_chk(CMD_FIRST_TRIAL_START, 1'b0);
		cmd_chk(CMD_SECOND_TRIAL_START, 1'b0);
		@(posedge CLOCK);
		TRIGGER <= 1'b1;
		rd(4'h8);
		`CHK(rd_val[1:0], 2'h1)
		@(posedge CLOCK);
		TRIGGER <= 1'b0;
		wr(4'h0, 32'h0000_0000);
	endtask

	// Online test: enable, one trigger window, quit
	task t_online;
		cmd_chk(CMD_ONLINE_TRIAL_ENABLE, 1'b1);
		rd(4'h8);
		`CHK(rd_val[6], 1'b1)
		@(posedge CLOCK);
		TRIGGER <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			@(posedge CLOCK);
			SCAN <= 1'b1;
			DECODE <= (i < 5);
			LABEL_TAG <= 16'h0033;
			@(posedge CLOCK);
			SCAN <= 1'b0;
			DECODE <= 1'b0;
		end
		cyc(4);
		TRIGGER <= 1'b0;
		#1 `CHK(REC.valid, 1'b0)
		wait_rec;
		`CHK(REC.kind, REC_ONLINE)
		`CHK(REC.good, 14'h0005)
		`CHK(REC.scan, 14'h0007)
		@(posedge CLOCK);
		#1 `CHK(SEGMENT, 5'h03)
		cmd_chk(CMD_QUIT, 1'b1);
		rd(4'h8);
		`CHK(rd_val[6], 1'b0)
	endtask

	// Status flashes, external outputs, settings-transfer hold
	task t_status;
		logic [1:0] w;
		@(posedge CLOCK);
		RESULT_FAIL <= 1'b1;
		@(posedge CLOCK);
		RESULT_FAIL <= 1'b0;
		SETUP_BUSY <= 1'b1;
		#1 `CHK(PASS_FAIL_BAD, 1'b1)
		`CHK(LAMP_RED, 1'b1)
		watch(5'h1f, w);
		`CHK(w, 2'b10)
		@(posedge CLOCK);
		SETUP_BUSY <= 1'b0;
		FAULT_SEL <= 2'h2;
		watch(5'h04, w);
		`CHK(w, 2'b10)
		@(posedge CLOCK);
		FAULT_SEL <= 2'h0;
		LINK_ERR <= 1'b1;
		@(posedge CLOCK);
		LINK_ERR <= 1'b0;
		watch(5'h10, w);
		`CHK(w, 2'b10)
		press();
		rd(4'h8);
		`CHK(rd_val[4], 1'b0)
		@(posedge CLOCK);
		BUTTON <= 1'b1;
		cyc(40);
		watch(5'h15, w);
		`CHK(w, 2'b10)
		@(posedge CLOCK);
		BUTTON <= 1'b0;
		rd(4'h8);
		`CHK(rd_val[3:2], 2'h3)
		@(posedge CLOCK);
		XFER_DONE <= 1'b1;
		@(posedge CLOCK);
		XFER_DONE <= 1'b0;
		rd(4'h8);
		`CHK(rd_val[3:2], 2'h1)
	endtask

	// Five-second hold, then lock and unlock
	task t_hold_lock;
		logic lit;
		@(posedge CLOCK);
		BUTTON <= 1'b1;
		cyc(24);
		#1 `CHK(SEGMENT, 5'h03)
		@(posedge CLOCK);
		BUTTON <= 1'b0;
		rd(4'h8);
		`CHK(rd_val[1:0], 2'h2)
		press();
		cmd_chk(CMD_LOCK, 1'b1);
		`CHK(LASER_ON, 1'b0)
		lit = 0;
		repeat (20) begin
			@(posedge CLOCK);
			#1 if (SEGMENT === 5'h01) lit = 1;
		end
		`CHK(lit, 1'b1)
		cmd_chk(CMD_UNLOCK, 1'b1);
		rd(4'h8);
		`CHK(rd_val[3:2], 2'h0)
	endtask

	// Verdict and end of run
	task print_verdict;
		$display("Errors %0d of %0d comparisons", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (8) @(posedge CLOCK);
		RST <= 1'b0;
		t_walk();
		t_tact();
		t_rate();
		t_trig();
		t_online();
		t_status();
		t_hold_lock();
		print_verdict();
	end
endmodule // testbench
`default_nettype wire
